// *** ent_pkg.sv ***
package ent_pkg;
	localparam int SAMPLE_BITS = 1;
	localparam int CLK_HZ = 200000000;
	localparam int SAMPLE_HZ_MAX = 200000;
	// Least ratio meeting the sample rate ceiling
	localparam int SAMPLE_DIV = (CLK_HZ + SAMPLE_HZ_MAX - 1) / SAMPLE_HZ_MAX;
	localparam int RCT_CUTOFF = 21;
	localparam int APT_WINDOW = 512;
	localparam int APT_CUTOFF = 410;
	localparam int SEED_BITS = 384;
	localparam int RESEED_BITS = 32;
	// Register offsets of the generator controller
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFF_RESEED = 8'h10;
	localparam logic [7:0] OFF_SEED_CNT = 8'h14;
	// Control bits
	localparam int CTRL_RESTART = 0;
	localparam int CTRL_SELFTEST = 1;
	localparam int CTRL_SLEEP = 2;
	localparam int CTRL_GEN = 3;
	// Interrupt bits
	localparam int IRQ_ERR = 0;
	localparam int IRQ_SEEDED = 1;
	localparam int IRQ_STFAIL = 2;
	localparam int IRQ_BITS = 3;
endpackage

// *** ent_if.sv ***
`timescale 1ns/100ps
interface ent_if;
	logic sleep;
	logic restart;
	logic bit_data;
	logic bit_valid;
	logic ready;
	logic health_err;
	modport source (input sleep, input restart,
		output bit_data, output bit_valid, output ready, output health_err);
	modport drbg (output sleep, output restart,
		input bit_data, input bit_valid, input ready, input health_err);
endinterface

// *** ent_source.sv ***
`timescale 1ns/100ps
module ent_source #(
	parameter int DIV = ent_pkg::SAMPLE_DIV,
	parameter int RCT_CUT = ent_pkg::RCT_CUTOFF,
	parameter int APT_WIN = ent_pkg::APT_WINDOW,
	parameter int APT_CUT = ent_pkg::APT_CUTOFF
)(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Analog noise comparator output
	input wire logic noise_in,
	// Link to generator
	ent_if.source lnk
);
	////////////////////////////////////////////////////////////////
	logic [2:0] sync_q;
	logic noise_q;
	logic [15:0] div_q;
	logic tick_q;
	logic [15:0] rct_cnt_q;
	logic [15:0] apt_cnt_q;
	logic [15:0] apt_pos_q;
	logic apt_ref_q;
	logic startup_q;
	logic ready_q;
	logic err_q;
	logic data_q;
	logic valid_q;
	logic hold_q;
	logic rct_fail;
	logic apt_fail;
	logic tests_on;
	logic restart_ev;
	logic restart_prev_q;
	logic sleep_prev_q;
	logic usable_d;
	// Health testing cannot be switched off
	assign tests_on = 1'b1;
	assign restart_ev = (lnk.restart & ~restart_prev_q) | (sleep_prev_q & ~lnk.sleep);

	////////////////////////////////////////////////////////////////
	// Pin synchroniser, change counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			sync_q <= 3'h0;
		else
			sync_q <= {sync_q[1:0], noise_in};

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			noise_q <= 1'b0;
		else if (sync_q[1] == sync_q[2])
			noise_q <= sync_q[2];

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			restart_prev_q <= 1'b0;
			sleep_prev_q <= 1'b0;
		end
		else
		begin
			restart_prev_q <= lnk.restart;
			sleep_prev_q <= lnk.sleep;
		end

	////////////////////////////////////////////////////////////////
	// Sample clock enable; sleep stops sampling
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			div_q <= 16'h0000;
			tick_q <= 1'b0;
		end
		else if (lnk.sleep)
		begin
			div_q <= 16'h0000;
			tick_q <= 1'b0;
		end
		else if (div_q == 16'(DIV - 1))
		begin
			div_q <= 16'h0000;
			tick_q <= 1'b1;
		end
		else
		begin
			div_q <= div_q + 16'h0001;
			tick_q <= 1'b0;
		end

	////////////////////////////////////////////////////////////////
	// Repetition count and adaptive proportion, one bit per sample
	assign rct_fail = tests_on && rct_cnt_q >= 16'(RCT_CUT);
	assign apt_fail = tests_on && apt_cnt_q >= 16'(APT_CUT);

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			rct_cnt_q <= 16'h0001;
		else if (restart_ev)
			rct_cnt_q <= 16'h0001;
		else if (tick_q)
			rct_cnt_q <= (noise_q == data_q) ? rct_cnt_q + 16'h0001 : 16'h0001;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			apt_pos_q <= 16'h0000;
			apt_cnt_q <= 16'h0000;
			apt_ref_q <= 1'b0;
		end
		else if (restart_ev)
		begin
			apt_pos_q <= 16'h0000;
			apt_cnt_q <= 16'h0000;
		end
		else if (tick_q)
		begin
			if (apt_pos_q == 16'h0000)
			begin
				apt_ref_q <= noise_q;
				apt_cnt_q <= 16'h0001;
			end
			else if (noise_q == apt_ref_q)
				apt_cnt_q <= apt_cnt_q + 16'h0001;
			apt_pos_q <= (apt_pos_q == 16'(APT_WIN - 1)) ? 16'h0000 : apt_pos_q + 16'h0001;
		end

	////////////////////////////////////////////////////////////////
	// Start-up cycle: one full proportion window must pass
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			startup_q <= 1'b1;
		else if (restart_ev)
			startup_q <= 1'b1;
		else if (tick_q && apt_pos_q == 16'(APT_WIN - 1))
			startup_q <= 1'b0;

	// Error is sticky; only a clean start-up cycle clears it
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			err_q <= 1'b0;
		else if (rct_fail || apt_fail)
			err_q <= 1'b1;
		else if (startup_q && tick_q && apt_pos_q == 16'(APT_WIN - 1) && !hold_q)
			err_q <= 1'b0;

	// Failure seen during the running start-up cycle blocks its pass
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			hold_q <= 1'b0;
		else if (restart_ev)
			hold_q <= 1'b0;
		else if (rct_fail || apt_fail)
			hold_q <= 1'b1;
		else if (tick_q && apt_pos_q == 16'(APT_WIN - 1))
			hold_q <= 1'b0;

	// Shared by ready and valid so no sample slips out as ready falls
	assign usable_d = ~startup_q & ~err_q & ~(rct_fail | apt_fail);

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ready_q <= 1'b0;
		else
			ready_q <= usable_d;

	////////////////////////////////////////////////////////////////
	// Raw bits go only to the generator, unconditioned
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			data_q <= 1'b0;
			valid_q <= 1'b0;
		end
		else
		begin
			if (tick_q)
				data_q <= noise_q;
			valid_q <= tick_q & usable_d;
		end

	assign lnk.bit_data = data_q;
	assign lnk.bit_valid = valid_q;
	assign lnk.ready = ready_q;
	assign lnk.health_err = err_q;
endmodule

// *** ent_drbg_ctl.sv ***
`timescale 1ns/100ps
module ent_drbg_ctl #(
	parameter int SEED_N = ent_pkg::SEED_BITS
)(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	// Seed material to generator core
	output logic seed_bit,
	output logic seed_bit_valid,
	output logic seeded,
	// Entropy source link
	ent_if.drbg lnk
);
	typedef enum {ST_IDLE, ST_WAIT, ST_SEED} state_t;
	state_t st_q;
	logic [31:0] reseed_q;
	logic [15:0] seed_cnt_q;
	logic [2:0] irq_stat_q;
	logic [2:0] irq_mask_q;
	logic sleep_q;
	logic restart_q;
	logic seeded_q;
	logic seed_bit_q;
	logic seed_valid_q;
	logic irq_q;
	logic [31:0] prdata_q;
	logic wr;
	logic rd;
	logic [2:0] ev;
	logic gen_pulse;
	logic st_req;
	logic inst_req;
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;
	assign gen_pulse = wr && paddr == ent_pkg::OFF_CTRL && pwdata[ent_pkg::CTRL_GEN];
	assign st_req = wr && paddr == ent_pkg::OFF_CTRL && pwdata[ent_pkg::CTRL_SELFTEST];
	// Wake or counter rollover re-instantiates
	assign inst_req = (sleep_q && wr && paddr == ent_pkg::OFF_CTRL && !pwdata[ent_pkg::CTRL_SLEEP])
		|| (gen_pulse && reseed_q == 32'hFFFFFFFF);

	////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			sleep_q <= 1'b0;
			restart_q <= 1'b0;
		end
		else
		begin
			if (wr && paddr == ent_pkg::OFF_CTRL)
				sleep_q <= pwdata[ent_pkg::CTRL_SLEEP];
			restart_q <= (wr && paddr == ent_pkg::OFF_CTRL && pwdata[ent_pkg::CTRL_RESTART])
				|| st_req || inst_req;
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			reseed_q <= 32'h00000000;
		else if (st_req || inst_req)
			reseed_q <= 32'h00000000;
		else if (gen_pulse && seeded_q)
			reseed_q <= reseed_q + 32'h00000001;

	// Seeding sequence after self-test, wake or rollover
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			st_q <= ST_WAIT;
			seed_cnt_q <= 16'h0000;
			seeded_q <= 1'b0;
		end
		else if (st_req || inst_req)
		begin
			st_q <= ST_WAIT;
			seed_cnt_q <= 16'h0000;
			seeded_q <= 1'b0;
		end
		else
			unique case (st_q)
				ST_IDLE:
					if (lnk.health_err)
					begin
						// Back to waiting so a clean restart can reseed
						st_q <= ST_WAIT;
						seed_cnt_q <= 16'h0000;
						seeded_q <= 1'b0;
					end
				ST_WAIT:
					if (lnk.ready && !restart_q)
						st_q <= ST_SEED;
				ST_SEED:
					if (lnk.health_err)
					begin
						st_q <= ST_WAIT;
						seed_cnt_q <= 16'h0000;
					end
					else if (lnk.bit_valid)
					begin
						if (seed_cnt_q == 16'(SEED_N - 1))
						begin
							st_q <= ST_IDLE;
							seeded_q <= 1'b1;
						end
						seed_cnt_q <= seed_cnt_q + 16'h0001;
					end
			endcase

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			seed_bit_q <= 1'b0;
			seed_valid_q <= 1'b0;
		end
		else
		begin
			seed_bit_q <= lnk.bit_data;
			seed_valid_q <= st_q == ST_SEED && lnk.bit_valid && !lnk.health_err;
		end

	////////////////////////////////////////////////////////////////
	// Interrupt status; set wins over write-one-to-clear
	assign ev[ent_pkg::IRQ_ERR] = lnk.health_err;
	assign ev[ent_pkg::IRQ_SEEDED] = st_q == ST_SEED && lnk.bit_valid && !lnk.health_err
		&& seed_cnt_q == 16'(SEED_N - 1);
	assign ev[ent_pkg::IRQ_STFAIL] = st_q == ST_SEED && lnk.health_err;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			irq_stat_q <= 3'h0;
		else if (wr && paddr == ent_pkg::OFF_IRQ_STAT)
			irq_stat_q <= (irq_stat_q & ~pwdata[2:0]) | ev;
		else
			irq_stat_q <= irq_stat_q | ev;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			irq_mask_q <= 3'h0;
		else if (wr && paddr == ent_pkg::OFF_IRQ_MASK)
			irq_mask_q <= pwdata[2:0];

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			irq_q <= 1'b0;
		else
			irq_q <= |(irq_stat_q & irq_mask_q);

	// Read data captured in setup, valid in access; no raw bits mapped
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			prdata_q <= 32'h00000000;
		else if (rd)
			unique case (paddr)
				ent_pkg::OFF_CTRL: prdata_q <= {29'h0, sleep_q, 2'h0};
				ent_pkg::OFF_STATUS: prdata_q <= {29'h0, lnk.ready, lnk.health_err, seeded_q};
				ent_pkg::OFF_IRQ_STAT: prdata_q <= {29'h0, irq_stat_q};
				ent_pkg::OFF_IRQ_MASK: prdata_q <= {29'h0, irq_mask_q};
				ent_pkg::OFF_RESEED: prdata_q <= reseed_q;
				ent_pkg::OFF_SEED_CNT: prdata_q <= {16'h0, seed_cnt_q};
				default: prdata_q <= 32'h00000000;
			endcase

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign irq = irq_q;
	assign seed_bit = seed_bit_q;
	assign seed_bit_valid = seed_valid_q;
	assign seeded = seeded_q;
	assign lnk.sleep = sleep_q;
	assign lnk.restart = restart_q;
endmodule

// *** ent_link_props.sv ***
`timescale 1ns/100ps
module ent_link_props #(
	parameter int DIV = ent_pkg::SAMPLE_DIV,
	parameter int APT_WIN = ent_pkg::APT_WINDOW
)(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link signals
	input wire logic sleep,
	input wire logic restart,
	input wire logic bit_data,
	input wire logic bit_valid,
	input wire logic ready,
	input wire logic health_err
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	int gap_q;
	int low_q;
	logic arm_q;
	////////////////////////////////
	// Counters, since a repetition cannot scale with DIV
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			gap_q <= 1000;
		else
			gap_q <= bit_valid ? 0 : gap_q + 1;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			low_q <= 0;
		else
			low_q <= ready ? 0 : low_q + 1;
	// Armed by restart or sleep, disarmed by a fresh error
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			arm_q <= 1'h0;
		else if (restart || sleep)
			arm_q <= 1'h1;
		else if ($rose(health_err))
			arm_q <= 1'h0;
	////////////////////////////////
	chk_valid_usable: assert property (bit_valid |-> ready && !health_err)
		else $error("sample offered while unusable");
	chk_err_ready: assert property (health_err [*2] |-> !ready)
		else $error("ready high during error");
	chk_sample_gap: assert property (bit_valid |-> gap_q >= DIV - 1)
		else $error("samples closer than divider");
	chk_full_window: assert property ($rose(ready) |-> low_q >= (APT_WIN - 1) * DIV)
		else $error("ready before a full window");
	chk_restart_drops: assert property (restart |-> ##[1:3] !ready)
		else $error("ready kept after restart");
	chk_wake_drops: assert property ($fell(sleep) |-> ##[1:3] !ready)
		else $error("ready kept after wake");
	chk_err_sticky: assert property ($fell(health_err) |-> arm_q)
		else $error("error cleared without restart");
	chk_restart_pulse: assert property (restart |=> !restart)
		else $error("restart longer than a cycle");
	c_ready: cover property ($rose(ready));
	c_err: cover property ($rose(health_err));
	c_wake: cover property ($fell(sleep));
endmodule

// *** tb_entropy_source_health_monitor.sv ***
`timescale 1ns/100ps
module tb_entropy_source_health_monitor;
	// Shortened divider and window, shared by design and checker
	localparam int DIV_T = 4;
	localparam int WIN_T = 16;
	logic pclk = 0;
	logic presetn = 0;
	logic noise_in = 0;
	logic stuck = 0;
	logic [1:0] ph = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic seeded;
	logic irq;
	logic seed_bit_valid;
	logic [31:0] rd;
	int num_errors = 0;
	int comparisons = 0;
	int sb_n = 0;
	int sb_base = 0;
	ent_if lnk();
	ent_source #(.DIV(DIV_T), .APT_WIN(WIN_T), .APT_CUT(14)) ent_source_inst (
		.pclk(pclk), .presetn(presetn), .noise_in(noise_in), .lnk(lnk));
	ent_drbg_ctl #(.SEED_N(8)) ent_drbg_ctl_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .seed_bit(),
		.seed_bit_valid(seed_bit_valid), .seeded(seeded), .lnk(lnk));
	ent_link_props #(.DIV(DIV_T), .APT_WIN(WIN_T)) ent_link_props_inst (.pclk(pclk),
		.presetn(presetn), .sleep(lnk.sleep), .restart(lnk.restart),
		.bit_data(lnk.bit_data), .bit_valid(lnk.bit_valid), .ready(lnk.ready),
		.health_err(lnk.health_err));
	////////////////////////////////
	always #2.5 pclk = ~pclk;
	// Flip once per sample so neither test trips on good noise
	always @(posedge pclk)
	begin
		ph <= ph + 2'h1;
		if (!stuck && ph == 2'h3)
			noise_in <= ~noise_in;
	end
	always @(posedge pclk)
		if (seed_bit_valid)
			sb_n <= sb_n + 1;
	////////////////////////////////
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Request held until pready is seen at a rising edge
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (!pready);
		rd = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wait_stat(logic [31:0] m, logic [31:0] v);
		int n;
		n = 0;
		do
		begin
			apb(1'h0, ent_pkg::OFF_STATUS, 32'h0);
			n++;
		end
		while ((rd & m) !== v && n < 500);
		check("status", rd & m, v);
	endtask
	// Seeding restarts: ready drops, then a full seed arrives
	task automatic reseed();
		wait_stat(32'h4, 32'h0);
		wait_stat(32'h5, 32'h5);
		repeat (100) @(posedge pclk);
		check("seed bits", sb_n - sb_base, 32'h8);
	endtask
	////////////////////////////////
	task automatic t_start();
		apb(1'h0, ent_pkg::OFF_STATUS, 32'h0);
		check("status at reset", rd, 32'h0);
		wait_stat(32'h5, 32'h5);
		repeat (100) @(posedge pclk);
		check("first seed bits", sb_n, 32'h8);
		apb(1'h0, 8'h20, 32'h0);
		check("unmapped", rd, 32'h0);
		check("unmapped error", pslverr, 32'h0);
		$display("start done");
	endtask
	task automatic t_fault();
		apb(1'h1, ent_pkg::OFF_IRQ_MASK, 32'h1);
		stuck <= 1'h1;
		wait_stat(32'h6, 32'h2);
		// Interrupt and seeded flag trail the error by up to two cycles
		repeat (2) @(posedge pclk);
		check("irq", irq, 32'h1);
		check("seeded dropped", seeded, 32'h0);
		stuck <= 1'h0;
		repeat (300) @(posedge pclk);
		apb(1'h0, ent_pkg::OFF_STATUS, 32'h0);
		check("err held", rd & 32'h6, 32'h2);
		apb(1'h1, ent_pkg::OFF_IRQ_MASK, 32'h0);
		apb(1'h0, ent_pkg::OFF_IRQ_STAT, 32'h0);
		check("irq masked", irq, 32'h0);
		sb_base = sb_n;
		apb(1'h1, ent_pkg::OFF_CTRL, 32'h1);
		reseed();
		check("err cleared", rd & 32'h2, 32'h0);
		apb(1'h1, ent_pkg::OFF_IRQ_STAT, 32'h7);
		apb(1'h1, ent_pkg::OFF_IRQ_MASK, 32'h1);
		apb(1'h0, ent_pkg::OFF_IRQ_STAT, 32'h0);
		check("err stat", rd & 32'h1, 32'h0);
		check("irq cleared", irq, 32'h0);
		$display("fault done");
	endtask
	task automatic t_self();
		apb(1'h1, ent_pkg::OFF_CTRL, 32'h8);
		apb(1'h1, ent_pkg::OFF_CTRL, 32'h8);
		apb(1'h0, ent_pkg::OFF_RESEED, 32'h0);
		check("reseed count", rd, 32'h2);
		sb_base = sb_n;
		apb(1'h1, ent_pkg::OFF_CTRL, 32'h2);
		apb(1'h0, ent_pkg::OFF_RESEED, 32'h0);
		check("count cleared", rd, 32'h0);
		reseed();
		check("seeded after self test", seeded, 32'h1);
		$display("self test done");
	endtask
	task automatic t_sleep();
		apb(1'h1, ent_pkg::OFF_CTRL, 32'h4);
		repeat (20) @(posedge pclk);
		sb_base = sb_n;
		apb(1'h1, ent_pkg::OFF_CTRL, 32'h0);
		reseed();
		$display("sleep done");
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		t_start();
		t_fault();
		t_self();
		t_sleep();
		stop_test();
	end
	// Tests need under two thousand cycles; this is 40000, over twenty times that
	initial
	begin
		#200000;
		num_errors++;
		stop_test();
	end
endmodule
